//--- core/readout_pkg.sv
// package: constants and carriers for the pixel array readout sequencer
package readout_pkg;
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned EXP_W           = 16;
  // default window: 3264 x 2448 active image, border of 8 excluded
  localparam logic [11:0] X_START_RST     = 12'h008;
  localparam logic [11:0] X_END_RST       = 12'hcc7;
  localparam logic [11:0] Y_START_RST     = 12'h008;
  localparam logic [11:0] Y_END_RST       = 12'h997;
  localparam logic [11:0] X_SIZE_RST      = 12'hcc0;
  localparam logic [11:0] Y_SIZE_RST      = 12'h990;
  localparam logic [2:0]  ODD_INC_RST     = 3'h1;
  localparam logic        H_REV_RST       = 1'h1;
  localparam logic        V_REV_RST       = 1'h0;
  localparam logic [15:0] EXP_RST         = 16'h0010;
  // bayer order codes (phase of the first delivered pixel)
  localparam logic [1:0]  BAYER_GR        = 2'h0;
  localparam logic [1:0]  BAYER_RG        = 2'h1;
  localparam logic [1:0]  BAYER_BG        = 2'h2;
  localparam logic [1:0]  BAYER_GB        = 2'h3;

  typedef struct packed {
    logic [11:0] x_start;
    logic [11:0] x_end;
    logic [11:0] y_start;
    logic [11:0] y_end;
    logic [11:0] x_size;
    logic [11:0] y_size;
    logic [2:0]  x_odd_inc;
    logic [2:0]  y_odd_inc;
    logic        h_rev;
    logic        v_rev;
    logic [15:0] exposure;
  } geom_t;

  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        sol;
    logic [11:0] col;
    logic [11:0] row;
  } pix_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_EXPO  = 5'b00010,
    ST_READ  = 5'b00100,
    ST_SHUT  = 5'b01000,
    ST_BLANK = 5'b10000
  } seq_state_t;
endpackage

//--- core/pixel_array_readout_sequencer.sv
// pixel array readout sequencer: window scan, reversal, skipping, shutter modes
// Contract
// [RULE1] rolling mode streams frames at fixed rate, resetting then reading rows in turn
// [RULE2] exposure is reset-to-read interval, identical for all rows of a frame
// [RULE3] exposure changes apply at frame start so frames never mix exposures
// [RULE4] global release mode captures one frame, drives external shutter controls
// [RULE5] scan bounded by start/end addresses; output dims follow size settings
// [RULE6] reset window gives 3264 by 2448 active image
// [RULE7] border pixels excluded by default, included only by enlarged settings
// [RULE8] column reversal on after reset; reads last column down to first
// [RULE9] row reversal reads last row first down to first row
// [RULE10] reversal changes update readable bayer phase field
// [RULE11] column and row odd increments programmed independently
// [RULE12] odd increment accepts only 1, 3, 7; 1 means no skipping
// [RULE13] both increments 3 give 2x2 skipping, quarter pixel count
// [RULE14] both increments 7 give 4x4 skipping, one sixteenth resolution
// [RULE15] standby halts sequencing while settings stay writable
// [RULE16] read an even/odd pair then advance n+1 from the pair start
// [RULE17] geometry changes take effect only at frame boundary
`timescale 1ns/100ps
module pixel_array_readout_sequencer (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 standby_i,
  input  wire logic                 global_release_mode_i,
  input  wire logic                 grab_i,
  input  wire readout_pkg::geom_t   cfg_i,
  output readout_pkg::pix_t         pix_o,
  output logic                      row_reset_o,
  output logic [11:0]               row_reset_addr_o,
  output logic                      shutter_open_o,
  output logic                      busy_o,
  output logic [1:0]                bayer_order_o,
  output logic                      frame_done_o
);
  readout_pkg::seq_state_t state_reg, state_next;
  readout_pkg::geom_t      geom_reg, geom_next;
  readout_pkg::geom_t      cfg_reg, cfg_next;
  readout_pkg::pix_t       pix_reg, pix_next;
  logic [11:0] col_reg, col_next, row_reg, row_next;
  logic [11:0] ocol_reg, ocol_next, orow_reg, orow_next;
  logic [11:0] rst_row_reg, rst_row_next;
  logic        half_reg, half_next, rrst_reg, rrst_next;
  logic [15:0] exp_cnt_reg, exp_cnt_next;
  logic [1:0]  bayer_reg, bayer_next;
  logic        done_reg, done_next, shut_reg, shut_next;
  logic        row_last, col_last, row_half;
  logic [11:0] xs, ys;

  // reset geometry: 3264 x 2448 active image, border excluded, column reversal on
  localparam readout_pkg::geom_t GEOM_RST = '{readout_pkg::X_START_RST, readout_pkg::X_END_RST,
                                               readout_pkg::Y_START_RST, readout_pkg::Y_END_RST,
                                               readout_pkg::X_SIZE_RST, readout_pkg::Y_SIZE_RST,
                                               readout_pkg::ODD_INC_RST, readout_pkg::ODD_INC_RST,
                                               readout_pkg::H_REV_RST, readout_pkg::V_REV_RST,
                                               readout_pkg::EXP_RST};

  // only 1, 3, 7 are legal; anything else falls back to no skipping
  function automatic logic [2:0] legal_inc(input logic [2:0] v);
    legal_inc = (v == 3'h3 || v == 3'h7) ? v : 3'h1; // [RULE12]
  endfunction

  // column step: within pair step 1, pair end jumps to pair start + n + 1
  function automatic logic [11:0] step(input logic h, input logic [2:0] n);
    step = h ? 12'(n) : 12'h001; // [RULE16]
  endfunction

  // latch programmed settings; keeps writing in standby so control access is never lost
  always_comb begin
    cfg_next = cfg_i; // [RULE15]
    cfg_next.x_odd_inc = legal_inc(cfg_i.x_odd_inc); // [RULE11]
    cfg_next.y_odd_inc = legal_inc(cfg_i.y_odd_inc); // [RULE11]
  end

  assign xs = geom_reg.h_rev ? geom_reg.x_end : geom_reg.x_start;
  assign ys = geom_reg.v_rev ? geom_reg.y_end : geom_reg.y_start;
  // line ends on output width or on crossing the far column bound
  assign col_last = (ocol_reg + 12'h001 >= geom_reg.x_size) ||
                    (geom_reg.h_rev ? (col_reg < geom_reg.x_start + step(half_reg, geom_reg.x_odd_inc))
                                    : (col_reg + step(half_reg, geom_reg.x_odd_inc) > geom_reg.x_end)); // [RULE5]
  // pair phase counted from the first row read, so a reversed scan also starts with a full pair
  assign row_half = row_reg[0] ^ ys[0]; // [RULE16]
  assign row_last = (orow_reg + 12'h001 >= geom_reg.y_size) ||
                    (geom_reg.v_rev ? (row_reg < geom_reg.y_start + step(row_half, geom_reg.y_odd_inc))
                                    : (row_reg + step(row_half, geom_reg.y_odd_inc) > geom_reg.y_end)); // [RULE9]

  // sequencer next-state and counters
  always_comb begin
    state_next   = state_reg;
    geom_next    = geom_reg;
    col_next     = col_reg;
    row_next     = row_reg;
    ocol_next    = ocol_reg;
    orow_next    = orow_reg;
    half_next    = half_reg;
    exp_cnt_next = exp_cnt_reg;
    rst_row_next = rst_row_reg;
    rrst_next    = 1'b0;
    done_next    = 1'b0;
    shut_next    = shut_reg;
    bayer_next   = bayer_reg;
    pix_next     = '0;
    unique case (state_reg)
      readout_pkg::ST_IDLE: begin
        // new geometry and exposure captured only here, at the frame boundary
        if (!standby_i && (!global_release_mode_i || grab_i)) begin // [RULE15]
          geom_next    = cfg_reg; // [RULE17] [RULE3]
          bayer_next   = {cfg_reg.v_rev ^ cfg_reg.y_start[0], cfg_reg.h_rev ^ cfg_reg.x_start[0]}; // [RULE10]
          exp_cnt_next = cfg_reg.exposure;
          rst_row_next = cfg_reg.v_rev ? cfg_reg.y_end : cfg_reg.y_start;
          row_next     = cfg_reg.v_rev ? cfg_reg.y_end : cfg_reg.y_start;
          col_next     = cfg_reg.h_rev ? cfg_reg.x_end : cfg_reg.x_start;
          ocol_next    = '0;
          orow_next    = '0;
          half_next    = 1'b0;
          shut_next    = global_release_mode_i; // [RULE4]
          rrst_next    = 1'b1; // first row reset; in global mode this is the only row reset of the frame
          state_next   = readout_pkg::ST_EXPO;
        end
      end
      readout_pkg::ST_EXPO: begin
        // in rolling mode every row waits the same full count between its reset and its read; global mode waits once per frame
        if (exp_cnt_reg == 16'h0000) begin // [RULE2]
          pix_next.sof = (orow_reg == 12'h000);
          if (geom_reg.x_size != 12'h000 && geom_reg.y_size != 12'h000) begin
            state_next = global_release_mode_i ? readout_pkg::ST_SHUT : readout_pkg::ST_READ;
          end else begin
            state_next = readout_pkg::ST_BLANK;
          end
        end else begin
          exp_cnt_next = exp_cnt_reg - 16'h0001;
        end
      end
      readout_pkg::ST_SHUT: begin
        // shutter closes to end exposure, then the frame is read out
        shut_next  = 1'b0; // [RULE4]
        state_next = readout_pkg::ST_READ;
      end
      readout_pkg::ST_READ: begin
        pix_next.valid = 1'b1;
        pix_next.sof   = (ocol_reg == 12'h000) && (orow_reg == 12'h000);
        pix_next.sol   = (ocol_reg == 12'h000);
        pix_next.col   = col_reg;
        pix_next.row   = row_reg;
        if (col_last) begin
          col_next  = xs;
          ocol_next = '0;
          half_next = 1'b0;
          if (row_last) begin
            state_next = readout_pkg::ST_BLANK;
          end else begin
            orow_next = orow_reg + 12'h001;
            row_next  = geom_reg.v_rev ? row_reg - step(row_half, geom_reg.y_odd_inc)
                                       : row_reg + step(row_half, geom_reg.y_odd_inc);
            // [RULE9] [RULE13] [RULE14]
            // rolling: reset the next row, expose it, then read it; line time grows by the exposure
            if (!global_release_mode_i) begin // [RULE1] [RULE2]
              rrst_next    = 1'b1;
              rst_row_next = row_next;
              exp_cnt_next = geom_reg.exposure;
              state_next   = readout_pkg::ST_EXPO;
            end
          end
        end else begin
          ocol_next = ocol_reg + 12'h001;
          half_next = ~half_reg;
          col_next  = geom_reg.h_rev ? col_reg - step(half_reg, geom_reg.x_odd_inc)
                                     : col_reg + step(half_reg, geom_reg.x_odd_inc); // [RULE8] [RULE16]
        end
      end
      readout_pkg::ST_BLANK: begin
        done_next  = 1'b1;
        state_next = readout_pkg::ST_IDLE; // rolling mode restarts at fixed cadence
      end
      default: state_next = readout_pkg::ST_IDLE;
    endcase
  end

  // state registers, synchronous active-low reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= readout_pkg::ST_IDLE;
      cfg_reg     <= GEOM_RST; // [RULE6] [RULE7] [RULE8]
      geom_reg    <= GEOM_RST;
      pix_reg     <= '0;
      col_reg     <= '0;
      row_reg     <= '0;
      ocol_reg    <= '0;
      orow_reg    <= '0;
      half_reg    <= 1'b0;
      exp_cnt_reg <= '0;
      rst_row_reg <= '0;
      rrst_reg    <= 1'b0;
      done_reg    <= 1'b0;
      shut_reg    <= 1'b0;
      bayer_reg   <= readout_pkg::BAYER_RG;
    end else begin
      state_reg   <= state_next;
      cfg_reg     <= cfg_next;
      geom_reg    <= geom_next;
      pix_reg     <= pix_next;
      col_reg     <= col_next;
      row_reg     <= row_next;
      ocol_reg    <= ocol_next;
      orow_reg    <= orow_next;
      half_reg    <= half_next;
      exp_cnt_reg <= exp_cnt_next;
      rst_row_reg <= rst_row_next;
      rrst_reg    <= rrst_next;
      done_reg    <= done_next;
      shut_reg    <= shut_next;
      bayer_reg   <= bayer_next;
    end
  end

  assign pix_o            = pix_reg;
  assign row_reset_o      = rrst_reg;
  assign row_reset_addr_o = rst_row_reg;
  assign shutter_open_o   = shut_reg;
  assign busy_o           = (state_reg != readout_pkg::ST_IDLE);
  assign bayer_order_o    = bayer_reg;
  assign frame_done_o     = done_reg;

  // assertions
  property p_geom_stable; // [RULE17]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == readout_pkg::ST_READ) |=> $stable(geom_reg);
  endproperty
  a_geom_stable: assert property (p_geom_stable) else $error("geometry changed mid frame");

  property p_inc_legal; // [RULE12]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      geom_reg.x_odd_inc inside {3'h1, 3'h3, 3'h7} && geom_reg.y_odd_inc inside {3'h1, 3'h3, 3'h7};
  endproperty
  a_inc_legal: assert property (p_inc_legal) else $error("illegal odd increment");

  property p_col_order; // [RULE8]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (pix_o.valid && !pix_o.sol && geom_reg.h_rev) |-> (pix_o.col < $past(pix_o.col));
  endproperty
  a_col_order: assert property (p_col_order) else $error("column order wrong under reversal");

  property p_standby_idle; // [RULE15]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (standby_i && state_reg == readout_pkg::ST_IDLE) |=> (state_reg == readout_pkg::ST_IDLE);
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("frame started in standby");

  property p_shutter_closed_read; // [RULE4]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == readout_pkg::ST_READ) |-> !shutter_open_o;
  endproperty
  a_shutter_closed_read: assert property (p_shutter_closed_read) else $error("shutter open during readout");

  property p_col_bound; // [RULE5]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      pix_o.valid |-> (pix_o.col >= geom_reg.x_start && pix_o.col <= geom_reg.x_end);
  endproperty
  a_col_bound: assert property (p_col_bound) else $error("column outside window");

  property p_bayer_track; // [RULE10]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == readout_pkg::ST_EXPO)
      |-> (bayer_order_o == {geom_reg.v_rev ^ geom_reg.y_start[0], geom_reg.h_rev ^ geom_reg.x_start[0]});
  endproperty
  a_bayer_track: assert property (p_bayer_track) else $error("bayer phase not updated");

  property p_exposure_load; // [RULE3]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_reg == readout_pkg::ST_IDLE && state_next == readout_pkg::ST_EXPO)
      |=> (exp_cnt_reg == geom_reg.exposure);
  endproperty
  a_exposure_load: assert property (p_exposure_load) else $error("exposure not loaded at frame start");

  // rolling row reset must open a full exposure count for that row
  sequence s_rolling_reset;
    row_reset_o && !global_release_mode_i;
  endsequence
  sequence s_full_exposure;
    (state_reg == readout_pkg::ST_EXPO) && (exp_cnt_reg == geom_reg.exposure);
  endsequence
  property p_reset_then_expose; // [RULE2]
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_rolling_reset |-> s_full_exposure;
  endproperty
  a_reset_then_expose: assert property (p_reset_then_expose) else $error("row reset without full exposure"); // [RULE2]
endmodule // pixel_array_readout_sequencer

//--- dv/pixel_sink.sv
// host-side sink model: collects the delivered pixel stream and per-frame counts
`timescale 1ns/100ps
module pixel_sink (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire readout_pkg::pix_t  pix_i,
  input  wire logic               busy_i,
  input  wire logic               row_reset_i,
  input  wire logic [11:0]        row_reset_addr_i,
  input  wire logic               frame_done_i
);
  logic [23:0] q[$];
  logic [11:0] rst_row = 12'h000;
  int          resets = 0;
  int          frames = 0;
  int          lat = 0;
  int          cnt = 0;
  int          since = 0;
  int          gap = -1;
  int          row_bad = 0;
  // always ready: the stream has no back-pressure, so a stalling host cannot be modelled
  always @(posedge sys_clk_i) begin
    cnt <= (!busy_i || !rst_n_i) ? 0 : cnt + 1;
    if (pix_i.valid) begin
      if (q.size() == 0) lat <= cnt;
      q.push_back({pix_i.col, pix_i.row});
    end
    if (row_reset_i) resets <= resets + 1;
    since <= row_reset_i ? 0 : since + 1;
    if (row_reset_i) rst_row <= row_reset_addr_i;
    if (frame_done_i) frames <= frames + 1;
    // a row opens on the row last reset, as far from that reset as the row before
    if (pix_i.valid && pix_i.sol) begin
      if (pix_i.row !== rst_row || (gap >= 0 && since != gap)) row_bad <= row_bad + 1;
      gap <= since;
    end
  end
endmodule // pixel_sink

//--- dv/pixel_array_readout_sequencer_bench.sv
// self-checking bench for the readout sequencer with a queue-based address model
`timescale 1ns/100ps
module pixel_array_readout_sequencer_bench;
  logic               sys_clk_i, rst_n_i, standby_i, global_release_mode_i, grab_i;
  readout_pkg::geom_t cfg_i, g;
  readout_pkg::pix_t  pix_o;
  logic               row_reset_o, shutter_open_o, busy_o, frame_done_o, bad;
  logic [11:0]        row_reset_addr_o;
  logic [1:0]         bayer_order_o;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;
  int                 k;
  logic [31:0]        seed = 32'h6c5ff924;
  logic [23:0]        exp_q[$];
  logic [2:0]         xi[6] = '{3'h1, 3'h3, 3'h7, 3'h5, 3'h1, 3'h7};
  logic [2:0]         yi[6] = '{3'h1, 3'h3, 3'h7, 3'h1, 3'h3, 3'h0};

  pixel_array_readout_sequencer u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
    .global_release_mode_i(global_release_mode_i), .grab_i(grab_i), .cfg_i(cfg_i), .pix_o(pix_o),
    .row_reset_o(row_reset_o), .row_reset_addr_o(row_reset_addr_o), .shutter_open_o(shutter_open_o),
    .busy_o(busy_o), .bayer_order_o(bayer_order_o), .frame_done_o(frame_done_o));
  pixel_sink u_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pix_i(pix_o), .busy_i(busy_o),
    .row_reset_i(row_reset_o), .row_reset_addr_i(row_reset_addr_o), .frame_done_i(frame_done_o));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // codes other than 3 and 7 behave as no skipping
  function automatic int eff(logic [2:0] v);
    return (v == 3'h3 || v == 3'h7) ? int'(v) : 1;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // window 16 columns by 8 rows, start parity random so bayer codes all occur
  task automatic set_cfg(logic [2:0] xinc, logic [2:0] yinc, logic [31:0] r);
    g.x_start = 12'h008 + 12'(r[0]);
    g.x_end = g.x_start + 12'h00f;
    g.y_start = 12'h008 + 12'(r[1]);
    g.y_end = g.y_start + 12'h007;
    g.x_size = 12'(32 / (eff(xinc) + 1));
    g.y_size = 12'(16 / (eff(yinc) + 1));
    g.x_odd_inc = xinc;
    g.y_odd_inc = yinc;
    g.h_rev = r[2];
    g.v_rev = r[3];
    g.exposure = 16'h0004 + 16'(r[7:4]);
    cfg_i = g;
  endtask
  // pairs of adjacent addresses, pair start stepping by n+1, from the end when reversed
  task automatic build();
    int xn, yn;
    logic [11:0] c, r;
    xn = eff(g.x_odd_inc);
    yn = eff(g.y_odd_inc);
    exp_q.delete();
    for (int j = 0; j < int'(g.y_size); j++) begin
      for (int i = 0; i < int'(g.x_size); i++) begin
        c = g.h_rev ? g.x_end - 12'(i / 2 * (xn + 1) + i % 2) : g.x_start + 12'(i / 2 * (xn + 1) + i % 2);
        r = g.v_rev ? g.y_end - 12'(j / 2 * (yn + 1) + j % 2) : g.y_start + 12'(j / 2 * (yn + 1) + j % 2);
        exp_q.push_back({c, r});
      end
    end
  endtask
  task automatic wait_done();
    k = 0;
    while (frame_done_o !== 1'b1 && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 3000) check("frame end", 0, 1);
    @(negedge sys_clk_i);
  endtask
  task automatic compare_frames(int n);
    check("pixel count", u_host.q.size(), exp_q.size() * n);
    foreach (u_host.q[m]) check("pixel address", u_host.q[m], exp_q[m % exp_q.size()]);
    u_host.q.delete();
    u_host.resets = 0;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // hang guard: six captures and four rolling frames need well under this
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    standby_i = 1'b0;
    global_release_mode_i = 1'b1;
    grab_i = 1'b0;
    cfg_i = '{readout_pkg::X_START_RST, readout_pkg::X_END_RST, readout_pkg::Y_START_RST, readout_pkg::Y_END_RST,
      readout_pkg::X_SIZE_RST, readout_pkg::Y_SIZE_RST, readout_pkg::ODD_INC_RST, readout_pkg::ODD_INC_RST,
      readout_pkg::H_REV_RST, readout_pkg::V_REV_RST, readout_pkg::EXP_RST};
    repeat (10) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    check("reset bayer", bayer_order_o, readout_pkg::BAYER_RG);
    // single captures with one skip/reversal combination each, geometry disturbed mid-frame
    for (int t = 0; t < 6; t++) begin
      set_cfg(xi[t], yi[t], rnd());
      build();
      @(negedge sys_clk_i);
      grab_i = 1'b1;
      k = 0;
      while (busy_o !== 1'b1 && k < 100) begin
        @(negedge sys_clk_i);
        k++;
      end
      grab_i = 1'b0;
      @(negedge sys_clk_i);
      check("shutter open", shutter_open_o, 1);
      cfg_i.x_odd_inc = 3'h7;
      cfg_i.h_rev = ~g.h_rev;
      cfg_i.exposure = 16'h0001;
      wait_done();
      check("shutter closed", shutter_open_o, 0);
      check("row resets", u_host.resets, 1);
      check("reset row", row_reset_addr_o, g.v_rev ? g.y_end : g.y_start);
      check("exposure delay", u_host.lat, int'(g.exposure) + 3);
      compare_frames(1);
      cfg_i = g;
      repeat (3) @(negedge sys_clk_i);
      check("bayer", bayer_order_o, {g.v_rev ^ g.y_start[0], g.h_rev ^ g.x_start[0]});
    end
    // rolling mode restarts by itself; two whole frames must match the model
    set_cfg(3'h3, 3'h1, rnd());
    build();
    global_release_mode_i = 1'b0;
    wait_done();
    u_host.q.delete();
    u_host.resets = 0;
    u_host.frames = 0;
    u_host.row_bad = 0;
    u_host.gap = -1;
    wait_done();
    wait_done();
    check("frames", u_host.frames, 2);
    check("rolling resets", u_host.resets, 2 * int'(g.y_size));
    check("row reset order", u_host.row_bad, 0);
    check("rolling delay", u_host.lat, int'(g.exposure) + 2);
    compare_frames(2);
    // standby lets the running frame finish, then nothing starts
    standby_i = 1'b1;
    k = 0;
    while (busy_o !== 1'b0 && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    bad = 1'b0;
    repeat (50) begin
      @(negedge sys_clk_i);
      if (busy_o !== 1'b0) bad = 1'b1;
    end
    check("standby idle", bad, 0);
    end_sim();
  end
endmodule // pixel_array_readout_sequencer_bench
